// [hdl/nv_access_pkg.sv]
package nv_access_pkg;
	// ==========================================================
	// Device register offsets in the I/O space
	localparam logic [5:0] CTRL_OFS    = 6'h1f;
	localparam logic [5:0] DATA_OFS    = 6'h20;
	localparam logic [5:0] ADDR_LO_OFS = 6'h21;
	localparam logic [5:0] ADDR_HI_OFS = 6'h22;

	// Control register fields
	localparam int RIE_BIT = 3;
	localparam int MWE_BIT = 2;
	localparam int WE_BIT  = 1;
	localparam int RE_BIT  = 0;

	// Reset values
	localparam logic [7:0]  DATA_RST = 8'h00;
	localparam logic [10:0] ADDR_RST = 11'h000;

	// ==========================================================
	// Array geometry
	localparam int         ADDR_W        = 11;
	localparam int         MEM_BYTES     = 2048;
	localparam logic       LARGE_VARIANT = 1'b1;

	// ==========================================================
	// Timing
	localparam logic [2:0] MWE_WINDOW  = 3'h4;
	localparam logic [2:0] READ_STALL  = 3'h4;
	localparam logic [2:0] WRITE_STALL = 3'h2;
	localparam int CLK_PERIOD_NS  = 100;
	localparam int WRITE_TIME_NS  = 3400000;
	localparam int WRITE_CYCLES   = WRITE_TIME_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Controller user registers
	localparam logic [3:0] U_ADDR     = 4'h0;
	localparam logic [3:0] U_WDATA    = 4'h1;
	localparam logic [3:0] U_CMD      = 4'h2;
	localparam logic [3:0] U_STATUS   = 4'h3;
	localparam logic [3:0] U_IRQ_STAT = 4'h4;
	localparam logic [3:0] U_IRQ_CLR  = 4'h5;
	localparam logic [3:0] U_IRQ_EN   = 4'h6;
	localparam logic [3:0] U_GIE      = 4'h7;
	localparam int CMD_READ_BIT  = 0;
	localparam int CMD_WRITE_BIT = 1;
	localparam int EV_READ_DONE  = 0;
	localparam int EV_WRITE_GO   = 1;
endpackage : nv_access_pkg

// [hdl/nv_bus_if.sv]
`timescale 1ns/1ps
interface nv_bus_if;
	logic [5:0] io_addr;           // I/O register address
	logic [7:0] io_wdata;          // Write data
	logic       io_we;             // One-cycle write strobe
	logic       io_re;             // One-cycle read strobe
	logic [7:0] io_rdata;          // Read data, cycle after io_re
	logic       core_stall;        // Core halted while high
	logic       ready_irq;         // Ready interrupt request
	logic       global_ie;         // Global interrupt enable
	logic       self_program_busy; // Flash self-programming active

	modport device (
		input  io_addr, io_wdata, io_we, io_re, global_ie, self_program_busy,
		output io_rdata, core_stall, ready_irq
	);
	modport host (
		output io_addr, io_wdata, io_we, io_re, global_ie, self_program_busy,
		input  io_rdata, core_stall, ready_irq
	);
endinterface : nv_bus_if

// [hdl/nv_access_ctrl.sv]
`timescale 1ns/1ps
module nv_access_ctrl
	import nv_access_pkg::*;
#(
	parameter int WRITE_TIME_CYC = WRITE_CYCLES
) (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic resetn_i,
	// Core side
	nv_bus_if.device  bus
);

	// ==========================================================
	// Address folding
	// Small variant ignores the top address bit
	function automatic logic [ADDR_W-1:0] fold_addr(input logic [ADDR_W-1:0] a);
		fold_addr = LARGE_VARIANT ? a : {1'b0, a[ADDR_W-2:0]};
	endfunction : fold_addr

	// ==========================================================
	// State
	logic [7:0]        mem [0:MEM_BYTES-1];
	logic [ADDR_W-1:0] nv_addr_reg;
	logic [7:0]        nv_data_reg;
	logic              ready_irq_enable;
	logic [2:0]        mwe_cnt;
	logic              write_strobe;
	logic              read_strobe;
	logic [15:0]       wr_cnt;
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0]        wr_byte;
	logic [2:0]        stall_cnt;
	logic [7:0]        rdata;
	logic              stall;
	logic              irq;

	// ==========================================================
	// Decode
	wire hit_ctrl    = bus.io_addr == CTRL_OFS;
	wire hit_data    = bus.io_addr == DATA_OFS;
	wire hit_lo      = bus.io_addr == ADDR_LO_OFS;
	wire hit_hi      = bus.io_addr == ADDR_HI_OFS;
	wire wr_ctrl     = bus.io_we & hit_ctrl;
	wire master_write_enable = mwe_cnt != 3'h0;
	wire start_write = wr_ctrl & bus.io_wdata[WE_BIT] & master_write_enable
		& ~write_strobe & ~bus.self_program_busy;
	wire start_read  = wr_ctrl & bus.io_wdata[RE_BIT] & ~write_strobe;
	wire addr_open   = ~write_strobe;
	wire write_done  = write_strobe & (wr_cnt == 16'h0001);
	wire [7:0] ctrl_view = {4'h0, ready_irq_enable, master_write_enable,
		write_strobe, read_strobe};

	// Read data selection
	wire [7:0] rd_mux =
		hit_ctrl ? ctrl_view :
		hit_data ? nv_data_reg :
		hit_lo   ? nv_addr_reg[7:0] :
		hit_hi   ? {5'h00, nv_addr_reg[ADDR_W-1:8]} : 8'h00;

	// Next values
	wire [2:0] next_stall_cnt =
		start_read  ? READ_STALL :
		start_write ? WRITE_STALL :
		(stall_cnt != 3'h0) ? stall_cnt - 3'h1 : 3'h0;
	wire next_irq = ready_irq_enable & bus.global_ie & ~write_strobe;

	// ==========================================================
	// Control register
	// Writing the strobe bit as zero never clears a write in flight
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ready_irq_enable <= 1'b0;
			mwe_cnt          <= 3'h0;
			read_strobe      <= 1'b0;
		end else begin
			if (wr_ctrl)
				ready_irq_enable <= bus.io_wdata[RIE_BIT];
			if (wr_ctrl && bus.io_wdata[MWE_BIT])
				mwe_cnt <= MWE_WINDOW;
			else if (master_write_enable)
				mwe_cnt <= mwe_cnt - 3'h1;
			read_strobe <= start_read;
		end
	end

	// ==========================================================
	// Self-timed write
	// Address and byte are latched so later data writes do no harm
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			write_strobe <= 1'b0;
			wr_cnt       <= 16'h0000;
			wr_addr      <= ADDR_RST;
			wr_byte      <= DATA_RST;
		end else if (start_write) begin
			write_strobe <= 1'b1;
			wr_cnt       <= 16'(WRITE_TIME_CYC);
			wr_addr      <= fold_addr(nv_addr_reg);
			wr_byte      <= nv_data_reg;
		end else if (write_strobe) begin
			wr_cnt <= wr_cnt - 16'h0001;
			if (write_done)
				write_strobe <= 1'b0;
		end
	end

	// Array commit at the end of the write time
	always_ff @(posedge clock_i) begin
		if (write_done)
			mem[wr_addr] <= wr_byte;
	end

	// ==========================================================
	// Address and data registers
	// Reset clears the address although software must still load it
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			nv_addr_reg <= ADDR_RST;
			nv_data_reg <= DATA_RST;
		end else begin
			if (bus.io_we && hit_lo && addr_open)
				nv_addr_reg[7:0] <= bus.io_wdata;
			if (bus.io_we && hit_hi && addr_open)
				nv_addr_reg[ADDR_W-1:8] <= bus.io_wdata[ADDR_W-9:0];
			if (start_read)
				nv_data_reg <= mem[fold_addr(nv_addr_reg)];
			else if (bus.io_we && hit_data)
				nv_data_reg <= bus.io_wdata;
		end
	end

	// ==========================================================
	// Core answers
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata     <= 8'h00;
			stall_cnt <= 3'h0;
			stall     <= 1'b0;
			irq       <= 1'b0;
		end else begin
			rdata     <= bus.io_re ? rd_mux : 8'h00;
			stall_cnt <= next_stall_cnt;
			stall     <= next_stall_cnt != 3'h0;
			irq       <= next_irq;
		end
	end

	assign bus.io_rdata   = rdata;
	assign bus.core_stall = stall;
	assign bus.ready_irq  = irq;

endmodule : nv_access_ctrl

// [hdl/nv_access_host.sv]
`timescale 1ns/1ps
module nv_access_host
	import nv_access_pkg::*;
(
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        resetn_i,
	// Software port
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        we_i,
	input  wire logic        re_i,
	output logic      [15:0] rdata_o,
	// Flash status and interrupt
	input  wire logic        self_program_busy_i,
	output logic             irq_o,
	// Device side
	nv_bus_if.host           bus
);

	typedef enum {
		S_IDLE, S_POLL, S_POLL_W, S_CHECK, S_ADDR_LO, S_ADDR_HI, S_DATA,
		S_MWE, S_WE, S_RE, S_GAP, S_STALL, S_RD, S_RD_W, S_RD_CAP
	} host_state_t;

	// ==========================================================
	// State
	host_state_t       state;
	host_state_t       next_state;
	logic              op_write;
	logic [ADDR_W-1:0] cmd_addr;
	logic [7:0]        cmd_data;
	logic [7:0]        read_byte;
	logic              gie_en;
	logic [1:0]        irq_stat;
	logic [1:0]        irq_en;
	logic [5:0]        io_addr;
	logic [7:0]        io_wdata;
	logic              io_we;
	logic              io_re;
	logic              spb;
	logic              gie;
	logic [5:0]        next_io_addr;
	logic [7:0]        next_io_wdata;
	logic              next_io_we;
	logic              next_io_re;

	// ==========================================================
	// Software decode
	wire idle    = state == S_IDLE;
	wire cmd_go  = we_i & (addr_i == U_CMD) & idle;
	wire ev_read = state == S_RD_CAP;
	wire ev_wr   = state == S_WE;
	wire [1:0] ev_set = {ev_wr, ev_read};
	wire [1:0] ev_clr = (we_i && addr_i == U_IRQ_CLR) ? wdata_i[1:0] : 2'h0;
	wire [15:0] u_mux =
		(addr_i == U_ADDR)     ? {5'h00, cmd_addr} :
		(addr_i == U_WDATA)    ? {8'h00, cmd_data} :
		(addr_i == U_STATUS)   ? {6'h00, bus.ready_irq, ~idle, read_byte} :
		(addr_i == U_IRQ_STAT) ? {14'h0000, irq_stat} :
		(addr_i == U_IRQ_EN)   ? {14'h0000, irq_en} :
		(addr_i == U_GIE)      ? {15'h0000, gie_en} : 16'h0000;

	// ==========================================================
	// Sequencer: S_POLL, S_ADDR_LO through S_RE and S_RD each issue one I/O access, other steps none
	always_comb begin
		next_state    = state;
		next_io_addr  = io_addr;
		next_io_wdata = io_wdata;
		next_io_we    = 1'b0;
		next_io_re    = 1'b0;
		case (state)
			S_IDLE: if (cmd_go) next_state = S_POLL;
			S_POLL: begin // wait for strobe and flash idle
				next_io_addr = CTRL_OFS;
				next_io_re   = 1'b1;
				next_state   = S_POLL_W;
			end
			S_POLL_W: next_state = S_CHECK;
			S_CHECK: next_state = (bus.io_rdata[WE_BIT] || spb) ? S_POLL : S_ADDR_LO;
			S_ADDR_LO: begin
				next_io_addr  = ADDR_LO_OFS;
				next_io_wdata = cmd_addr[7:0];
				next_io_we    = 1'b1;
				next_state    = S_ADDR_HI;
			end
			S_ADDR_HI: begin
				next_io_addr  = ADDR_HI_OFS;
				next_io_wdata = {5'h00, cmd_addr[ADDR_W-1:8]};
				next_io_we    = 1'b1;
				next_state    = op_write ? S_DATA : S_RE;
			end
			S_DATA: begin
				next_io_addr  = DATA_OFS;
				next_io_wdata = cmd_data;
				next_io_we    = 1'b1;
				next_state    = S_MWE;
			end
			S_MWE: begin // enable with strobe written zero
				next_io_addr  = CTRL_OFS;
				next_io_wdata = (8'h01 << MWE_BIT) | (8'h01 << RIE_BIT);
				next_io_we    = 1'b1;
				next_state    = S_WE;
			end
			S_WE: begin // strobe in the very next cycle
				next_io_addr  = CTRL_OFS;
				next_io_wdata = (8'h01 << WE_BIT) | (8'h01 << RIE_BIT);
				next_io_we    = 1'b1;
				next_state    = S_GAP;
			end
			S_RE: begin
				next_io_addr  = CTRL_OFS;
				next_io_wdata = (8'h01 << RE_BIT) | (8'h01 << RIE_BIT);
				next_io_we    = 1'b1;
				next_state    = S_GAP;
			end
			S_GAP: next_state = S_STALL;
			S_STALL: if (!bus.core_stall) next_state = op_write ? S_IDLE : S_RD;
			S_RD: begin
				next_io_addr = DATA_OFS;
				next_io_re   = 1'b1;
				next_state   = S_RD_W;
			end
			S_RD_W: next_state = S_RD_CAP;
			S_RD_CAP: next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	// Bus outputs and sequencer state
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state    <= S_IDLE;
			io_addr  <= 6'h00;
			io_wdata <= 8'h00;
			io_we    <= 1'b0;
			io_re    <= 1'b0;
			spb      <= 1'b0;
			gie      <= 1'b0;
		end else begin
			state    <= next_state;
			io_addr  <= next_io_addr;
			io_wdata <= next_io_wdata;
			io_we    <= next_io_we;
			io_re    <= next_io_re;
			spb      <= self_program_busy_i;
			gie      <= gie_en & (next_state == S_IDLE);
		end
	end

	// ==========================================================
	// Software registers; an event beats its clear in the same cycle
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_addr  <= ADDR_RST;
			cmd_data  <= DATA_RST;
			op_write  <= 1'b0;
			gie_en    <= 1'b0;
			irq_en    <= 2'h0;
			irq_stat  <= 2'h0;
			read_byte <= 8'h00;
			rdata_o   <= 16'h0000;
			irq_o     <= 1'b0;
		end else begin
			if (we_i && addr_i == U_ADDR && idle)
				cmd_addr <= wdata_i[ADDR_W-1:0];
			if (we_i && addr_i == U_WDATA && idle)
				cmd_data <= wdata_i[7:0];
			if (we_i && addr_i == U_IRQ_EN)
				irq_en <= wdata_i[1:0];
			if (we_i && addr_i == U_GIE)
				gie_en <= wdata_i[0];
			if (cmd_go)
				op_write <= wdata_i[CMD_WRITE_BIT];
			if (ev_read)
				read_byte <= bus.io_rdata;
			irq_stat <= (irq_stat & ~ev_clr) | ev_set;
			rdata_o  <= re_i ? u_mux : 16'h0000;
			irq_o    <= |(irq_stat & irq_en);
		end
	end

	assign bus.io_addr           = io_addr;
	assign bus.io_wdata          = io_wdata;
	assign bus.io_we             = io_we;
	assign bus.io_re             = io_re;
	assign bus.global_ie         = gie;
	assign bus.self_program_busy = spb;

endmodule : nv_access_host

// [tb/nv_access_assertions.sv]
`timescale 1ns/1ps
// ==========================================================
// Checker on the bus between host end and device end
module nv_access_assertions
	import nv_access_pkg::*;
#(
	parameter int WRITE_TIME_CYC = WRITE_CYCLES
) (
	// Clock and reset
	input wire logic       clock_i,
	input wire logic       resetn_i,
	// Bus signals
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic       io_we,
	input wire logic       io_re,
	input wire logic [7:0] io_rdata,
	input wire logic       core_stall,
	input wire logic       ready_irq,
	input wire logic       global_ie,
	input wire logic       self_program_busy
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// Enable window and write age rebuilt from traffic
	logic [2:0] win;
	int         age;
	wire        ctrl_wr = io_we && (io_addr == CTRL_OFS);
	wire        ctrl_rd = io_re && (io_addr == CTRL_OFS);
	wire        wr_go   = ctrl_wr && io_wdata[WE_BIT] && (win != 3'h0) && !self_program_busy;
	wire        in_wr   = (age >= 1) && (age <= WRITE_TIME_CYC - 2);
	wire        wr_over = age >= WRITE_TIME_CYC + 2;
	// Age saturates so an idle bus does not wrap the count
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			win <= 3'h0;
			age <= 0;
		end else begin
			win <= (ctrl_wr && io_wdata[MWE_BIT]) ? MWE_WINDOW : ((win != 3'h0) ? win - 3'h1 : win);
			age <= wr_go ? 1 : ((age != 0 && age < WRITE_TIME_CYC + 8) ? age + 1 : age);
		end
	end
	AST_RDATA_IDLE: assert property (io_rdata != 8'h00 |-> $past(io_re))
		else $error("read data outside answer cycle");
	AST_CTRL_RSVD: assert property ($past(ctrl_rd) |-> io_rdata[7:4] == 4'h0)
		else $error("control reserved bits not zero");
	AST_ADDR_RSVD: assert property ($past(io_re) && $past(io_addr) == ADDR_HI_OFS
		|-> io_rdata[7:3] == 5'h00)
		else $error("address high reserved bits not zero");
	AST_READ_STALL: assert property (ctrl_wr && io_wdata[RE_BIT] && !io_wdata[WE_BIT]
		|=> core_stall [*4] ##1 !core_stall)
		else $error("read stall not four cycles");
	AST_WRITE_STALL: assert property (wr_go |=> core_stall [*2] ##1 !core_stall)
		else $error("write stall not two cycles");
	AST_MWE_EXPIRE: assert property ($past(ctrl_rd) && $past(win) == 3'h0
		|-> !io_rdata[MWE_BIT])
		else $error("master enable outlived window");
	AST_WRITE_BUSY: assert property ($past(ctrl_rd) && $past(in_wr) |-> io_rdata[WE_BIT])
		else $error("write strobe cleared early");
	AST_WRITE_DONE: assert property ($past(ctrl_rd) && $past(wr_over) |-> !io_rdata[WE_BIT])
		else $error("write strobe not cleared");
	AST_IRQ_GATED: assert property (!$past(global_ie) |-> !ready_irq)
		else $error("ready interrupt without global enable");
	AST_IRQ_WRITING: assert property (wr_go |-> ##2 !ready_irq [*3])
		else $error("ready interrupt during write");
endmodule : nv_access_assertions

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
	import nv_access_pkg::*;
	localparam int WT = 20;
	// ==========================================================
	// Clock, reset and software port
	logic        clock_i             = 1'b0;
	logic        resetn_i            = 1'b0;
	logic [3:0]  addr_i              = 4'h0;
	logic [15:0] wdata_i             = 16'h0000;
	logic        we_i                = 1'b0;
	logic        re_i                = 1'b0;
	logic        self_program_busy_i = 1'b0;
	logic [15:0] rdata_o;
	logic        irq_o;
	logic [15:0] s;
	int          n_mismatch          = 0;
	int          checks              = 0;
	always #50 clock_i = ~clock_i;
	// ==========================================================
	// Two ends joined by the interface, checker beside it
	nv_bus_if bus_if ();
	nv_access_ctrl #(.WRITE_TIME_CYC(WT)) u_nv_access_ctrl (.clock_i(clock_i),
		.resetn_i(resetn_i), .bus(bus_if.device));
	nv_access_host u_nv_access_host (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
		.self_program_busy_i(self_program_busy_i), .irq_o(irq_o), .bus(bus_if.host));
	nv_access_assertions #(.WRITE_TIME_CYC(WT)) u_nv_access_assertions (.clock_i(clock_i),
		.resetn_i(resetn_i), .io_addr(bus_if.io_addr), .io_wdata(bus_if.io_wdata),
		.io_we(bus_if.io_we), .io_re(bus_if.io_re), .io_rdata(bus_if.io_rdata),
		.core_stall(bus_if.core_stall), .ready_irq(bus_if.ready_irq),
		.global_ie(bus_if.global_ie), .self_program_busy(bus_if.self_program_busy));
	// ==========================================================
	// Shared tasks
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic ureg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		we_i    <= 1'b1;
		@(posedge clock_i);
		we_i    <= 1'b0;
	endtask : ureg_wr
	// Data stands for one cycle only, so it is taken just after that edge
	task automatic ureg_rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock_i);
		addr_i <= a;
		re_i   <= 1'b1;
		@(posedge clock_i);
		re_i   <= 1'b0;
		#1 d = rdata_o;
	endtask : ureg_rd
	task automatic wait_idle();
		for (int i = 0; i < 300; i++) begin
			ureg_rd(U_STATUS, s);
			if (s[8] === 1'b0) return;
		end
		n_mismatch++;
		$display("CHECK FAILED busy wait expected 0 seen 1");
		give_verdict();
	endtask : wait_idle
	task automatic start(input logic [10:0] a, input logic [7:0] d, input logic [15:0] c);
		ureg_wr(U_ADDR, {5'h00, a});
		ureg_wr(U_WDATA, {8'h00, d});
		ureg_wr(U_CMD, c);
	endtask : start
	task automatic rd_byte(input logic [10:0] a, input logic [7:0] exp);
		start(a, 8'h00, 16'h0001);
		wait_idle();
		chk("read byte", {8'h00, exp}, {8'h00, s[7:0]});
	endtask : rd_byte
	// ==========================================================
	// Scenarios
	task automatic t_edges();
		start(11'h7ff, 8'ha5, 16'h0002);
		wait_idle();
		start(11'h000, 8'h5a, 16'h0002);
		wait_idle();
		start(11'h400, 8'hc3, 16'h0002);
		wait_idle();
		rd_byte(11'h7ff, 8'ha5);
		rd_byte(11'h000, 8'h5a);
		rd_byte(11'h400, 8'hc3);
		ureg_rd(U_IRQ_STAT, s);
		chk("irq status", 16'h0003, s & 16'h0003);
		$display("test edges done");
	endtask : t_edges
	task automatic t_busy_refuse();
		start(11'h155, 8'h3c, 16'h0002);
		ureg_wr(U_ADDR, 16'h07ff);
		ureg_wr(U_WDATA, 16'h00ff);
		wait_idle();
		ureg_wr(U_CMD, 16'h0001);
		wait_idle();
		chk("kept address", 16'h003c, {8'h00, s[7:0]});
		rd_byte(11'h7ff, 8'ha5);
		$display("test busy refuse done");
	endtask : t_busy_refuse
	task automatic t_flash_busy();
		ureg_wr(U_IRQ_CLR, 16'h0003);
		self_program_busy_i <= 1'b1;
		start(11'h2aa, 8'h96, 16'h0002);
		repeat (60) @(posedge clock_i);
		ureg_rd(U_IRQ_STAT, s);
		chk("write held off", 16'h0000, s & 16'h0002);
		self_program_busy_i <= 1'b0;
		wait_idle();
		ureg_rd(U_IRQ_STAT, s);
		chk("write after flash", 16'h0002, s & 16'h0002);
		rd_byte(11'h2aa, 8'h96);
		$display("test flash busy done");
	endtask : t_flash_busy
	task automatic irq_is(input logic exp);
		repeat (2) @(posedge clock_i);
		#1 chk("irq output", {15'h0000, exp}, {15'h0000, irq_o});
	endtask : irq_is
	task automatic t_irq();
		ureg_wr(U_IRQ_EN, 16'h0001);
		irq_is(1'b1);
		ureg_wr(U_IRQ_EN, 16'h0000);
		irq_is(1'b0);
		ureg_wr(U_IRQ_EN, 16'h0001);
		irq_is(1'b1);
		ureg_wr(U_IRQ_CLR, 16'h0001);
		irq_is(1'b0);
		// Ready interrupt follows global enable and the write strobe
		ureg_wr(U_GIE, 16'h0000);
		repeat (2) @(posedge clock_i);
		ureg_rd(U_STATUS, s);
		chk("ready irq gated", 16'h0000, s & 16'h0200);
		ureg_wr(U_GIE, 16'h0001);
		repeat (2) @(posedge clock_i);
		ureg_rd(U_STATUS, s);
		chk("ready irq idle", 16'h0200, s & 16'h0200);
		start(11'h0aa, 8'h11, 16'h0002);
		wait_idle();
		ureg_rd(U_STATUS, s);
		chk("ready irq writing", 16'h0000, s & 16'h0200);
		repeat (30) @(posedge clock_i);
		ureg_rd(U_STATUS, s);
		chk("ready irq after write", 16'h0200, s & 16'h0200);
		$display("test irq done");
	endtask : t_irq
	// Main sequence after a six cycle reset
	initial begin
		repeat (6) @(posedge clock_i);
		resetn_i <= 1'b1;
		ureg_wr(U_GIE, 16'h0001);
		t_edges();
		t_busy_refuse();
		t_flash_busy();
		t_irq();
		give_verdict();
	end
endmodule : tb
